// [logic/pmsal_status.sv]
// status and alarm latching with clear faults and output enable
//
// Contract
// - fixed capability, revision, config accepted, unreadable
// - output enabled by pin and operation command
// - live off bit follows output state continuously
// - alarm bits latch until clear faults
// - clear faults clears all latched bits
// - persisting fault sets its bit again
`timescale 1ns/1ns
`default_nettype none
module pmsal_status
  import pmsal_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // decoded bus transactions
  input  wire logic       wr_i,         // one-cycle write strobe
  input  wire logic [7:0] wr_cmd_i,     // command code
  input  wire logic [7:0] wr_data_i,    // data byte
  input  wire logic       rd_i,         // one-cycle read strobe
  input  wire logic [7:0] rd_cmd_i,     // command code to read
  // block write framing
  input  wire logic       bw_start_i,
  input  wire logic       bw_byte_vld_i,
  input  wire logic [7:0] bw_byte_i,
  input  wire logic       bw_pec_ok_i,
  input  wire logic       bw_stop_i,
  // supply conditions
  input  wire logic       output_control_pin_i, // high enables output
  input  wire logic       output_on_i,          // live output state
  input  wire logic       oc_cond_i,            // overcurrent present
  input  wire logic       shdn_cond_i,          // shutdown present
  // results
  output logic            output_enable_o,
  output logic [7:0]      rd_data_o,
  output logic            rd_nack_o,
  output logic            bw_ack_o,
  output logic            bw_done_o,
  output logic            bw_err_o
);
  // -----------------------------------------------------------------
  // block write tracker
  // -----------------------------------------------------------------
  pmsal_bw_if bw_if ();
  assign bw_if.start    = bw_start_i;
  assign bw_if.byte_vld = bw_byte_vld_i;
  assign bw_if.byte_val = bw_byte_i;
  assign bw_if.pec_ok   = bw_pec_ok_i;
  assign bw_if.stop     = bw_stop_i;
  assign bw_ack_o       = bw_if.ack;
  assign bw_done_o      = bw_if.done;
  assign bw_err_o       = bw_if.err;

  pmsal_block_write u_bw (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .bw      (bw_if.ctl)
  );

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  logic [7:0]               op_reg;     // operation command value
  logic [7:0]               next_op_reg;
  logic [PMSAL_ALARM_W-1:0] alarm;      // {cml, shutdown, overcurrent}
  logic [PMSAL_ALARM_W-1:0] next_alarm;
  logic [7:0]               rd_data;
  logic [7:0]               next_rd_data;
  logic                     rd_nack;
  logic                     next_rd_nack;
  logic                     clear;      // clear faults strobe
  logic [PMSAL_ALARM_W-1:0] cond;       // present fault conditions
  logic [7:0]               status_byte;

  assign clear = wr_i && wr_cmd_i == PMSAL_CMD_CLEAR_FLT;
  assign cond  = {bw_if.err, shdn_cond_i, oc_cond_i};

  // output is on only when both the pin and the command allow it
  assign output_enable_o = output_control_pin_i && op_reg[PMSAL_OP_ON_BIT];

  // status byte: off bit is live, the rest latched
  always_comb begin
    status_byte                    = 8'h00;
    status_byte[PMSAL_ST_OFF_BIT]  = !output_on_i;
    status_byte[PMSAL_ST_OC_BIT]   = alarm[0];
    status_byte[PMSAL_ST_SHDN_BIT] = alarm[1];
    status_byte[PMSAL_ST_CML_BIT]  = alarm[2];
  end

  // next values for command, alarms and read answer
  always_comb begin
    next_op_reg  = op_reg;
    next_rd_data = rd_data;
    next_rd_nack = 1'b0;
    // clear drops everything, but a present condition wins over it
    next_alarm   = (clear ? PMSAL_ALARM_RESET : alarm) | cond;
    if (wr_i) begin
      case (wr_cmd_i)
        PMSAL_CMD_OPERATION: next_op_reg = wr_data_i;
        // fixed settings: taken and discarded
        PMSAL_CMD_ONOFF_CFG,
        PMSAL_CMD_CAPABILITY,
        PMSAL_CMD_PMBUS_REV: next_op_reg = op_reg;
        default:             next_op_reg = op_reg;
      endcase
    end
    if (rd_i) begin
      case (rd_cmd_i)
        PMSAL_CMD_OPERATION:   next_rd_data = op_reg;
        PMSAL_CMD_STATUS_BYTE,
        PMSAL_CMD_STATUS_WORD: next_rd_data = status_byte;
        default: begin
          // unreadable fixed settings and unknown codes are refused
          next_rd_data = 8'h00;
          next_rd_nack = 1'b1;
        end
      endcase
    end
  end

  // registers only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op_reg  <= PMSAL_OP_RESET;
      alarm   <= PMSAL_ALARM_RESET;
      rd_data <= 8'h00;
      rd_nack <= 1'b0;
    end else begin
      op_reg  <= next_op_reg;
      alarm   <= next_alarm;
      rd_data <= next_rd_data;
      rd_nack <= next_rd_nack;
    end
  end

  assign rd_data_o = rd_data;
  assign rd_nack_o = rd_nack;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  // a written operation value reaches the enable one edge later
  property p_enable;
    @(posedge clk_i) disable iff (!rst_n_i)
    wr_i && wr_cmd_i == PMSAL_CMD_OPERATION
      |=> output_enable_o == (output_control_pin_i && $past(wr_data_i[PMSAL_OP_ON_BIT]));
  endproperty
  a_enable: assert property (p_enable)
    else $error("output enable not pin and command");

  property p_oc_latch;
    @(posedge clk_i) disable iff (!rst_n_i)
    oc_cond_i ##1 !clear [*2] |-> alarm[0];
  endproperty
  a_oc_latch: assert property (p_oc_latch)
    else $error("overcurrent alarm did not stay latched");

  property p_clear;
    @(posedge clk_i) disable iff (!rst_n_i)
    clear && cond == 3'h0 |=> alarm == PMSAL_ALARM_RESET;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear faults left a bit set");

  property p_reassert;
    @(posedge clk_i) disable iff (!rst_n_i)
    clear && shdn_cond_i |=> alarm[1];
  endproperty
  a_reassert: assert property (p_reassert)
    else $error("persisting shutdown not set again");

  property p_live;
    @(posedge clk_i) disable iff (!rst_n_i)
    rd_i && rd_cmd_i == PMSAL_CMD_STATUS_BYTE
      |=> rd_data_o[PMSAL_ST_OFF_BIT] == !$past(output_on_i);
  endproperty
  a_live: assert property (p_live)
    else $error("off bit not live");

  property p_unreadable;
    @(posedge clk_i) disable iff (!rst_n_i)
    rd_i && rd_cmd_i == PMSAL_CMD_CAPABILITY |=> rd_nack_o && rd_data_o == 8'h00;
  endproperty
  a_unreadable: assert property (p_unreadable)
    else $error("fixed setting was readable");

  c_clear_persist: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    clear && oc_cond_i);
  c_op_off: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_i && wr_cmd_i == PMSAL_CMD_OPERATION && wr_data_i == 8'h00);
  c_latched_read: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_i && alarm != 3'h0 && cond == 3'h0);
endmodule
`default_nettype wire

// [shared/pmsal_pkg.sv]
// package of constants and types for the status and alarm latching block
`default_nettype none
package pmsal_pkg;
  // -----------------------------------------------------------------
  // command codes seen by the block
  // -----------------------------------------------------------------
  localparam logic [7:0] PMSAL_CMD_OPERATION   = 8'h01;
  localparam logic [7:0] PMSAL_CMD_ONOFF_CFG   = 8'h02;
  localparam logic [7:0] PMSAL_CMD_CLEAR_FLT   = 8'h03;
  localparam logic [7:0] PMSAL_CMD_CAPABILITY  = 8'h19;
  localparam logic [7:0] PMSAL_CMD_PMBUS_REV   = 8'h98;
  localparam logic [7:0] PMSAL_CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] PMSAL_CMD_STATUS_WORD = 8'h79;
  // -----------------------------------------------------------------
  // fixed settings accepted but never read back
  // -----------------------------------------------------------------
  localparam logic [7:0] PMSAL_CAPABILITY_VAL  = 8'h30; // 400 khz, alert
  localparam logic [7:0] PMSAL_PMBUS_REV_VAL   = 8'h22; // revision 1.2
  localparam logic [7:0] PMSAL_ONOFF_CFG_VAL   = 8'h1e; // pin and command
  // -----------------------------------------------------------------
  // operation command field and reset value
  // -----------------------------------------------------------------
  localparam int         PMSAL_OP_ON_BIT       = 7;
  localparam logic [7:0] PMSAL_OP_RESET        = 8'h80;
  // -----------------------------------------------------------------
  // status byte field positions
  // -----------------------------------------------------------------
  localparam int         PMSAL_ST_OFF_BIT      = 6; // live output off
  localparam int         PMSAL_ST_OC_BIT       = 4; // latched overcurrent
  localparam int         PMSAL_ST_SHDN_BIT     = 3; // latched shutdown
  localparam int         PMSAL_ST_CML_BIT      = 1; // latched bus error
  localparam int         PMSAL_ALARM_W         = 3;
  localparam logic [PMSAL_ALARM_W-1:0] PMSAL_ALARM_RESET = 3'h0;
  // -----------------------------------------------------------------
  // block write states
  // -----------------------------------------------------------------
  typedef enum logic [4:0] {
    PMSAL_BW_IDLE  = 5'h01,
    PMSAL_BW_COUNT = 5'h02,
    PMSAL_BW_DATA  = 5'h04,
    PMSAL_BW_PEC   = 5'h08,
    PMSAL_BW_STOP  = 5'h10
  } pmsal_bw_state_t;
endpackage
`default_nettype wire

// [shared/pmsal_bw_if.sv]
// interface carrying block write framing events between the two modules
`timescale 1ns/1ns
`default_nettype none
interface pmsal_bw_if;
  logic       start;    // block write begins, command taken
  logic       byte_vld; // one byte received
  logic [7:0] byte_val; // byte value
  logic       pec_ok;   // received pec matched
  logic       stop;     // stop condition seen
  logic       ack;      // acknowledge for this byte
  logic       done;     // framed block write completed
  logic       err;      // framing broke
  modport ctl (input start, byte_vld, byte_val, pec_ok, stop,
               output ack, done, err);
  modport src (output start, byte_vld, byte_val, pec_ok, stop,
               input ack, done, err);
endinterface
`default_nettype wire

// [logic/pmsal_block_write.sv]
// block write framing tracker: count, data, pec, acknowledge, stop
`timescale 1ns/1ns
`default_nettype none
module pmsal_block_write
  import pmsal_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // framing events
  pmsal_bw_if.ctl   bw
);
  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  pmsal_bw_state_t state;      // framing position
  pmsal_bw_state_t next_state;
  logic [7:0]      remain;     // data bytes still expected
  logic [7:0]      next_remain;

  // next state: count, data and good pec bytes are acked; a bad pec or an extra byte is not
  always_comb begin
    next_state  = state;
    next_remain = remain;
    bw.ack      = 1'b0;
    bw.done     = 1'b0;
    bw.err      = 1'b0;
    case (state)
      PMSAL_BW_IDLE: begin
        if (bw.start) begin
          next_state = PMSAL_BW_COUNT;
        end
      end
      PMSAL_BW_COUNT: begin
        if (bw.byte_vld) begin
          bw.ack      = 1'b1;
          next_remain = bw.byte_val;
          // an empty block goes straight to the check byte
          next_state  = (bw.byte_val == 8'h00) ? PMSAL_BW_PEC : PMSAL_BW_DATA;
        end
      end
      PMSAL_BW_DATA: begin
        if (bw.byte_vld) begin
          bw.ack      = 1'b1;
          next_remain = remain - 8'h01;
          if (remain == 8'h01) begin
            next_state = PMSAL_BW_PEC;
          end
        end
      end
      PMSAL_BW_PEC: begin
        if (bw.byte_vld) begin
          bw.ack     = bw.pec_ok;
          next_state = bw.pec_ok ? PMSAL_BW_STOP : PMSAL_BW_IDLE;
          bw.err     = !bw.pec_ok;
        end
      end
      PMSAL_BW_STOP: begin
        if (bw.stop) begin
          bw.done    = 1'b1;
          next_state = PMSAL_BW_IDLE;
        end else if (bw.byte_vld) begin
          bw.err     = 1'b1; // extra byte after the check byte
          next_state = PMSAL_BW_IDLE;
        end
      end
      default: begin
        next_state = PMSAL_BW_IDLE;
      end
    endcase
    // a stop in mid frame abandons it
    if (bw.stop && state != PMSAL_BW_STOP && state != PMSAL_BW_IDLE) begin
      bw.err     = 1'b1;
      next_state = PMSAL_BW_IDLE;
    end
  end

  // registers only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state  <= PMSAL_BW_IDLE;
      remain <= 8'h00;
    end else begin
      state  <= next_state;
      remain <= next_remain;
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  property p_done_after_pec;
    @(posedge clk_i) disable iff (!rst_n_i)
    // the stop wait is only entered right after an acked good check byte
    state == PMSAL_BW_STOP && $past(state) != PMSAL_BW_STOP
      |-> $past(bw.byte_vld && bw.pec_ok && bw.ack);
  endproperty
  a_done_after_pec: assert property (p_done_after_pec)
    else $error("block write done without check byte");
  c_block_done: cover property (@(posedge clk_i) disable iff (!rst_n_i) bw.done);
endmodule
`default_nettype wire

// [tb/pmsal_host_model.sv]
// host side model: drives decoded bus transactions into the block
`timescale 1ns/1ns
`default_nettype none
module pmsal_host_model (
  // clock
  input  wire logic  clk_i,
  // decoded transactions
  output logic       wr_o,
  output logic [7:0] wr_cmd_o,
  output logic [7:0] wr_data_o,
  output logic       rd_o,
  output logic [7:0] rd_cmd_o,
  // block write framing
  output logic       bw_start_o,
  output logic       bw_byte_vld_o,
  output logic [7:0] bw_byte_o,
  output logic       bw_pec_ok_o,
  output logic       bw_stop_o
);
  // -------------------------------------------------------------
  // idle bus, strobes low at time zero
  // -------------------------------------------------------------
  initial begin
    {wr_o, rd_o, bw_start_o, bw_byte_vld_o, bw_pec_ok_o, bw_stop_o} = '0;
    {wr_cmd_o, wr_data_o, rd_cmd_o, bw_byte_o} = '0;
  end
  // one-cycle write; released buses flip so stale data never looks valid
  task automatic put_write(input logic [7:0] cmd, input logic [7:0] data);
    @(posedge clk_i);
    {wr_o, wr_cmd_o, wr_data_o} <= {1'b1, cmd, data};
    @(posedge clk_i);
    {wr_o, wr_cmd_o, wr_data_o} <= {1'b0, ~cmd, ~data};
  endtask
  // one-cycle read request
  task automatic put_read(input logic [7:0] cmd);
    @(posedge clk_i);
    {rd_o, rd_cmd_o} <= {1'b1, cmd};
    @(posedge clk_i);
    {rd_o, rd_cmd_o} <= {1'b0, ~cmd};
  endtask
  // block write command byte taken
  task automatic put_start();
    @(posedge clk_i);
    bw_start_o <= 1'b1;
    @(posedge clk_i);
    bw_start_o <= 1'b0;
  endtask
  // count, data or pec byte; pec_ok only qualifies the pec byte
  task automatic put_byte(input logic [7:0] b, input logic ok);
    @(posedge clk_i);
    {bw_byte_vld_o, bw_byte_o, bw_pec_ok_o} <= {1'b1, b, ok};
    @(posedge clk_i);
    {bw_byte_vld_o, bw_byte_o, bw_pec_ok_o} <= {1'b0, ~b, 1'b0};
  endtask
  // stop closes the frame after the pec acknowledge
  task automatic put_stop();
    @(posedge clk_i);
    bw_stop_o <= 1'b1;
    @(posedge clk_i);
    bw_stop_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the status and alarm latching block
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import pmsal_pkg::*;
;
  // -------------------------------------------------------------
  // nets, queues and counters
  // -------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_n_i, output_control_pin_i, output_on_i, oc_cond_i, shdn_cond_i;
  logic wr_i, rd_i, bw_start_i, bw_byte_vld_i, bw_pec_ok_i, bw_stop_i;
  logic [7:0] wr_cmd_i, wr_data_i, rd_cmd_i, bw_byte_i, rd_data_o;
  logic output_enable_o, rd_nack_o, bw_ack_o, bw_done_o, bw_err_o, rd_seen;
  logic [8:0] rd_q[$];   // expected {nack, data} per read
  logic [2:0] bw_q[$];   // expected {ack, done, err} per frame event
  logic [31:0] seed = 32'd75447;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  always #4 clk_i = ~clk_i;
  pmsal_status pmsal_status_i (.clk_i, .rst_n_i, .wr_i, .wr_cmd_i, .wr_data_i, .rd_i,
    .rd_cmd_i, .bw_start_i, .bw_byte_vld_i, .bw_byte_i, .bw_pec_ok_i, .bw_stop_i,
    .output_control_pin_i, .output_on_i, .oc_cond_i, .shdn_cond_i, .output_enable_o,
    .rd_data_o, .rd_nack_o, .bw_ack_o, .bw_done_o, .bw_err_o);
  pmsal_host_model pmsal_host_model_i (.clk_i(clk_i), .wr_o(wr_i), .wr_cmd_o(wr_cmd_i),
    .wr_data_o(wr_data_i), .rd_o(rd_i), .rd_cmd_o(rd_cmd_i), .bw_start_o(bw_start_i),
    .bw_byte_vld_o(bw_byte_vld_i), .bw_byte_o(bw_byte_i), .bw_pec_ok_o(bw_pec_ok_i),
    .bw_stop_o(bw_stop_i));
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected status byte, refusal flag clear
  function automatic logic [8:0] st(input logic off, oc, sd, cml);
    logic [8:0] v;
    v = 9'h0;
    v[PMSAL_ST_OFF_BIT] = off;
    v[PMSAL_ST_OC_BIT] = oc;
    v[PMSAL_ST_SHDN_BIT] = sd;
    v[PMSAL_ST_CML_BIT] = cml;
    return v;
  endfunction
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [7:0] cmd, input logic [8:0] exp);
    rd_q.push_back(exp);
    pmsal_host_model_i.put_read(cmd);
  endtask
  // whole frame: count, n data, pec, and stop only after a good pec
  task automatic frame(input int n, input logic good);
    pmsal_host_model_i.put_start();
    bw_q.push_back(3'b100);
    pmsal_host_model_i.put_byte(n[7:0], 1'b0);
    for (int k = 0; k < n; k++) begin
      seed = lfsr_next(seed);
      bw_q.push_back(3'b100);
      pmsal_host_model_i.put_byte(seed[7:0], 1'b0);
    end
    bw_q.push_back(good ? 3'b100 : 3'b001);
    pmsal_host_model_i.put_byte(seed[15:8], good);
    if (good) begin
      bw_q.push_back(3'b010);
      pmsal_host_model_i.put_stop();
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // -------------------------------------------------------------
  // watcher: read answer lands one edge after the strobe
  // -------------------------------------------------------------
  always @(posedge clk_i) rd_seen <= rd_i;
  always @(negedge clk_i) begin
    if (rd_seen && rd_q.size() != 0) begin
      check("read", {rd_nack_o, rd_data_o}, rd_q.pop_front());
    end
    if ((bw_byte_vld_i || bw_stop_i) && bw_q.size() != 0) begin
      check("frame", {6'h0, bw_ack_o, bw_done_o, bw_err_o}, {6'h0, bw_q.pop_front()});
    end
  end
  // hang guard, about 109 cycles are really needed
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      num_errors++;
      report_and_stop();
    end
  end
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    logic [7:0] fixed[3];
    fixed = '{PMSAL_CMD_ONOFF_CFG, PMSAL_CMD_CAPABILITY, PMSAL_CMD_PMBUS_REV};
    {rst_n_i, output_control_pin_i, output_on_i, oc_cond_i, shdn_cond_i} = 5'b01100;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd_chk(PMSAL_CMD_OPERATION, {1'b0, PMSAL_OP_RESET});
    // fixed settings taken but refused on read
    for (int i = 0; i < 3; i++) begin
      seed = lfsr_next(seed);
      pmsal_host_model_i.put_write(fixed[i], seed[7:0]);
      rd_chk(fixed[i], 9'h100);
    end
    // fixed settings must leave the operation value alone
    rd_chk(PMSAL_CMD_OPERATION, {1'b0, PMSAL_OP_RESET});
    // pin and operation bit both gate the output
    for (int i = 0; i < 4; i++) begin
      seed = lfsr_next(seed);
      @(posedge clk_i) output_control_pin_i <= i[1];
      pmsal_host_model_i.put_write(PMSAL_CMD_OPERATION, {i[0], seed[6:0]});
      @(negedge clk_i);
      check("enable", {8'h0, output_enable_o}, {8'h0, i[1] & i[0]});
    end
    // live off bit follows output state
    rd_chk(PMSAL_CMD_STATUS_BYTE, st(1'b0, 1'b0, 1'b0, 1'b0));
    @(posedge clk_i) output_on_i <= 1'b0;
    rd_chk(PMSAL_CMD_STATUS_BYTE, st(1'b1, 1'b0, 1'b0, 1'b0));
    // brief overcurrent stays latched, bad pec latches bus error
    @(posedge clk_i) oc_cond_i <= 1'b1;
    @(posedge clk_i) oc_cond_i <= 1'b0;
    rd_chk(PMSAL_CMD_STATUS_BYTE, st(1'b1, 1'b1, 1'b0, 1'b0));
    frame(2, 1'b1);
    frame(0, 1'b1);
    frame(1, 1'b0);
    rd_chk(PMSAL_CMD_STATUS_BYTE, st(1'b1, 1'b1, 1'b0, 1'b1));
    pmsal_host_model_i.put_write(PMSAL_CMD_CLEAR_FLT, 8'h00);
    rd_chk(PMSAL_CMD_STATUS_BYTE, st(1'b1, 1'b0, 1'b0, 1'b0));
    // shutdown still present across clear is flagged again
    @(posedge clk_i) shdn_cond_i <= 1'b1;
    pmsal_host_model_i.put_write(PMSAL_CMD_CLEAR_FLT, 8'h00);
    rd_chk(PMSAL_CMD_STATUS_BYTE, st(1'b1, 1'b0, 1'b1, 1'b0));
    @(posedge clk_i) shdn_cond_i <= 1'b0;
    pmsal_host_model_i.put_write(PMSAL_CMD_CLEAR_FLT, 8'h00);
    rd_chk(PMSAL_CMD_STATUS_BYTE, st(1'b1, 1'b0, 1'b0, 1'b0));
    // a stop inside the data bytes abandons the frame as a bus error
    pmsal_host_model_i.put_start();
    bw_q.push_back(3'b100);
    pmsal_host_model_i.put_byte(8'h03, 1'b0);
    bw_q.push_back(3'b001);
    pmsal_host_model_i.put_stop();
    rd_chk(PMSAL_CMD_STATUS_BYTE, st(1'b1, 1'b0, 1'b0, 1'b1));
    // mid-run reset drops the latched alarm and restores the operation value
    @(posedge clk_i) rst_n_i <= 1'b0;
    @(posedge clk_i) rst_n_i <= 1'b1;
    rd_chk(PMSAL_CMD_OPERATION, {1'b0, PMSAL_OP_RESET});
    rd_chk(PMSAL_CMD_STATUS_BYTE, st(1'b1, 1'b0, 1'b0, 1'b0));
    repeat (4) @(posedge clk_i);
    report_and_stop();
  end
endmodule
`default_nettype wire
